// ==== hdl/adc_seq_pkg.sv ====
/*
 * Constants shared by the converter sequencer: control word fields, frame
 * edge counts, bus offsets and reset values.
 * Assumes a 12-bit serial control word sent MSB first, 16-bit result frames.
 */
package adc_seq_pkg;
    localparam int FRAME_BITS = 16;
    localparam int WORD_BITS = 12;
    localparam int CTRL_BITS = 11;
    localparam int DATA_BITS = 12;
    localparam int FIFO_DEPTH = 32;
    // Control word fields (bit 11 is the load enable and is never stored).
    localparam int WRITE_POS = 11;
    localparam int SEQ_HI_POS = 10;
    localparam int CH_HI_POS = 7;
    localparam int CH_LO_POS = 6;
    localparam int PM_HI_POS = 5;
    localparam int PM_LO_POS = 4;
    localparam int SEQ_LO_POS = 3;
    localparam int RANGE_POS = 1;
    localparam int CODING_POS = 0;
    localparam logic [CTRL_BITS-1:0] CTRL_RESET = 11'h033;
    // Falling serial clock edges within a frame.
    localparam logic [4:0] EDGE_SAR_START = 5'h01;
    localparam logic [4:0] EDGE_DONE = 5'h0d;
    localparam logic [4:0] EDGE_MUX = 5'h0e;
    localparam logic [4:0] EDGE_LAST = 5'h0f;
    // Resolution select codes.
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;
    localparam logic [1:0] CFG_RESET = RES_12;
    // Wishbone byte offsets.
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CFG = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam logic [3:0] OFS_STATUS = 4'hc;
    typedef enum logic {LINK_IDLE, LINK_FRAME} link_e;
endpackage

// ==== hdl/adc_channel_sequencer.sv ====
/*
 * Result FIFO and the sequencer/control top of a four-channel SAR converter.
 * Assumes a host serial master on cs_n/sclk/din/dout, an analog front end
 * driven by channel, hold, range and trial-code outputs that answers on
 * comparator_i, and a classic Wishbone master on clk_i.
 */
`timescale 1ns/100ps

module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];
    assign count_o = cnt_q;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module adc_channel_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    output logic dout_o,
    output logic dout_oe_o,
    input wire logic comparator_i,
    output logic [1:0] channel_o,
    output logic hold_o,
    output logic range_o,
    output logic [1:0] power_mode_o,
    output logic [adc_seq_pkg::DATA_BITS-1:0] trial_code_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);
    import adc_seq_pkg::*;

    // ****************************************
    // Pin synchronisers and edge detection
    // ****************************************
    logic [1:0] cs_s_q;
    logic [1:0] sclk_s_q;
    logic [1:0] din_s_q;
    logic [1:0] comp_s_q;
    logic cs_last_q;
    logic sclk_last_q;
    logic cs_fall;
    logic cs_rise;
    logic sclk_fall;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cs_s_q <= 2'h3;
            sclk_s_q <= 2'h3;
            din_s_q <= 2'h0;
            comp_s_q <= 2'h0;
            cs_last_q <= 1'b1;
            sclk_last_q <= 1'b1;
        end else begin
            cs_s_q <= {cs_s_q[0], cs_n_i};
            sclk_s_q <= {sclk_s_q[0], sclk_i};
            din_s_q <= {din_s_q[0], din_i};
            comp_s_q <= {comp_s_q[0], comparator_i};
            cs_last_q <= cs_s_q[1];
            sclk_last_q <= sclk_s_q[1];
        end
    end

    assign cs_fall = cs_last_q && !cs_s_q[1];
    assign cs_rise = !cs_last_q && cs_s_q[1];
    assign sclk_fall = sclk_last_q && !sclk_s_q[1] && !cs_s_q[1];

    // ****************************************
    // Frame tracking
    // ****************************************
    link_e link_q;
    logic [4:0] edge_q;
    logic [WORD_BITS-1:0] din_word_q;
    logic edge_mux;
    logic edge_done;

    assign edge_mux = sclk_fall && (edge_q == EDGE_MUX - 5'h01);
    assign edge_done = sclk_fall && (edge_q == EDGE_DONE - 5'h01);

    always_ff @(posedge clk_i) begin
        if (rst_i || cs_rise) begin
            link_q <= LINK_IDLE;
            edge_q <= '0;
        end else if (cs_fall) begin
            link_q <= LINK_FRAME;
            edge_q <= '0;
        end else if (sclk_fall && link_q == LINK_FRAME && edge_q != 5'h1f) begin
            edge_q <= edge_q + 5'h01;
        end
    end

    // Control bits are clocked in on the first twelve falling edges.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            din_word_q <= '0;
        end else if (sclk_fall && edge_q < 5'(WORD_BITS)) begin
            din_word_q <= {din_word_q[WORD_BITS-2:0], din_s_q[1]};
        end
    end

    // ****************************************
    // Control register and sequencer
    // ****************************************
    logic [CTRL_BITS-1:0] ctrl_q;
    logic seq_active_q;
    logic [1:0] final_ch_q;
    logic [1:0] channel_q;
    logic [1:0] conv_ch_q;
    logic conv_coding_q;
    logic wr_en;
    logic [1:0] seq_mode;
    logic [1:0] wr_ch;
    logic [1:0] seq_next;

    assign wr_en = din_word_q[WRITE_POS];
    assign seq_mode = {din_word_q[SEQ_HI_POS], din_word_q[SEQ_LO_POS]};
    assign wr_ch = {din_word_q[CH_HI_POS], din_word_q[CH_LO_POS]};
    assign seq_next = (conv_ch_q == final_ch_q) ? 2'h0 : conv_ch_q + 2'h1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (edge_mux && wr_en) begin
            ctrl_q <= din_word_q[CTRL_BITS-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_active_q <= 1'b0;
            final_ch_q <= '0;
            channel_q <= '0;
        end else if (edge_mux) begin
            if (wr_en && seq_mode == 2'h3) begin
                seq_active_q <= 1'b1;
                final_ch_q <= wr_ch;
                channel_q <= 2'h0;
            end else if (wr_en && seq_mode == 2'h2 && seq_active_q) begin
                channel_q <= seq_next;
            end else if (wr_en) begin
                seq_active_q <= 1'b0;
                channel_q <= wr_ch;
            end else if (seq_active_q) begin
                channel_q <= seq_next;
            end else begin
                channel_q <= {ctrl_q[CH_HI_POS], ctrl_q[CH_LO_POS]};
            end
        end
    end

    // The channel and coding in force are frozen when the sample is taken.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_ch_q <= '0;
            conv_coding_q <= CTRL_RESET[CODING_POS];
        end else if (cs_fall) begin
            conv_ch_q <= channel_q;
            conv_coding_q <= ctrl_q[CODING_POS];
        end
    end

    assign channel_o = channel_q;
    assign range_o = ctrl_q[RANGE_POS];
    assign power_mode_o = {ctrl_q[PM_HI_POS], ctrl_q[PM_LO_POS]};

    // ****************************************
    // Successive approximation engine
    // ****************************************
    logic [1:0] res_q;
    logic [DATA_BITS-1:0] res_mask;
    logic [DATA_BITS-1:0] dac_q;
    logic [DATA_BITS-1:0] dac_d;
    logic [DATA_BITS-1:0] coded;
    logic [FRAME_BITS-1:0] frame_word;
    logic hold_q;

    // Coarser variants only try the top bits, so one code step is wider.
    always_comb begin
        unique case (res_q)
            RES_8: res_mask = 12'hff0;
            RES_10: res_mask = 12'hffc;
            default: res_mask = 12'hfff;
        endcase
    end

    // Trial for bit 12-n is set on fall n; it is resolved on fall n+1.
    always_comb begin
        int rb;
        int tb;
        rb = 13 - int'(edge_q + 5'h01);
        tb = rb - 1;
        dac_d = dac_q;
        if (edge_q + 5'h01 == EDGE_SAR_START) begin
            dac_d = 12'h800;
        end else if (edge_q + 5'h01 <= EDGE_DONE) begin
            if (!comp_s_q[1]) begin
                dac_d[rb[3:0]] = 1'b0;
            end
            if (tb >= 0) begin
                dac_d[tb[3:0]] = res_mask[tb[3:0]];
            end
        end
        dac_d = dac_d & res_mask;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dac_q <= '0;
        end else if (sclk_fall && edge_q < EDGE_DONE) begin
            dac_q <= dac_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || edge_done || cs_rise) begin
            hold_q <= 1'b0;
        end else if (cs_fall) begin
            hold_q <= 1'b1;
        end
    end

    assign trial_code_o = dac_q;
    assign hold_o = hold_q;
    assign coded = {dac_q[DATA_BITS-1] ^ !conv_coding_q, dac_q[DATA_BITS-2:0]};
    assign frame_word = {2'h0, conv_ch_q, coded};

    // ****************************************
    // Serial data out
    // ****************************************
    logic dout_q;
    logic oe_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || cs_rise) begin
            dout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (cs_fall) begin
            dout_q <= 1'b0;
            oe_q <= 1'b1;
        end else if (sclk_fall && edge_q < EDGE_LAST) begin
            dout_q <= frame_word[4'(EDGE_LAST - 5'h01 - edge_q)];
        end
    end

    assign dout_o = dout_q;
    assign dout_oe_o = oe_q;

    // ****************************************
    // Result capture into the FIFO
    // ****************************************
    logic [FRAME_BITS-1:0] pend_q;
    logic pend_valid_q;
    logic overflow_q;
    logic in_ready;
    logic [FRAME_BITS-1:0] fifo_data;
    logic fifo_valid;
    logic fifo_pop;
    logic [5:0] fifo_count;
    logic ovf_clear;
    logic [DATA_BITS-1:0] final_code;

    assign final_code = dac_d;

    // A full FIFO stalls the pending word; a later result then counts as lost.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_valid_q <= 1'b0;
            pend_q <= '0;
        end else if (edge_done && !(pend_valid_q && !in_ready)) begin
            pend_valid_q <= 1'b1;
            pend_q <= {2'h0, conv_ch_q, final_code[DATA_BITS-1] ^ !conv_coding_q,
                       final_code[DATA_BITS-2:0]};
        end else if (in_ready) begin
            pend_valid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_q <= 1'b0;
        end else if (edge_done && pend_valid_q && !in_ready) begin
            overflow_q <= 1'b1;
        end else if (ovf_clear) begin
            overflow_q <= 1'b0;
        end
    end

    result_fifo #(
        .WIDTH(FRAME_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(pend_q),
        .in_valid_i(pend_valid_q),
        .in_ready_o(in_ready),
        .out_data_o(fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .count_o(fifo_count)
    );

    // ****************************************
    // Wishbone slave
    // ****************************************
    logic ack_q;
    logic [31:0] rdata_q;
    logic wb_req;

    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign fifo_pop = wb_req && !wb_we_i && wb_adr_i == OFS_RESULT;
    assign ovf_clear = wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_STATUS
                       && wb_dat_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            res_q <= CFG_RESET;
        end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CFG) begin
            res_q <= (wb_dat_i[1:0] > RES_12) ? RES_12 : wb_dat_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= wb_req;
            rdata_q <= '0;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    OFS_CTRL: rdata_q <= {13'h0, seq_active_q, final_ch_q, channel_q,
                                          3'h0, ctrl_q};
                    OFS_CFG: rdata_q <= {30'h0, res_q};
                    OFS_RESULT: rdata_q <= {15'h0, fifo_valid, fifo_data};
                    OFS_STATUS: rdata_q <= {18'h0, fifo_count, 6'h0, !fifo_valid,
                                            overflow_q};
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ****************************************
    // Assertions
    // ****************************************
    a_seq_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_mux && !wr_en && seq_active_q && conv_ch_q == final_ch_q
        |=> channel_q == 2'h0)
        else $error("sequence did not wrap to channel zero");
    a_load_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_mux && !wr_en |=> $stable(ctrl_q))
        else $error("control register changed without load enable");
    a_mux_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(channel_q) |-> $past(edge_mux))
        else $error("channel changed off the fourteenth edge");
    a_manual_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_mux && wr_en && !seq_mode[1]
        |=> channel_q == $past(wr_ch) && !seq_active_q)
        else $error("manual channel select failed");
    a_seq_start: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_mux && wr_en && seq_mode == 2'h3
        |=> seq_active_q && channel_q == 2'h0 ##0 final_ch_q == $past(wr_ch))
        else $error("sequence did not start at channel zero");
    a_seq_keep: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_mux && wr_en && seq_mode == 2'h2 && seq_active_q
        |=> seq_active_q && $stable(final_ch_q))
        else $error("mode 10 interrupted the sequence");
    a_seq_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_mux && wr_en && seq_mode == 2'h0 |=> !seq_active_q)
        else $error("sequence not left on mode 00");
    a_cs_advance: assert property (@(posedge clk_i) disable iff (rst_i)
        cs_fall |=> conv_ch_q == $past(channel_q))
        else $error("converted channel not taken at frame start");
    a_coding_msb: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_done && !(pend_valid_q && !in_ready)
        |=> pend_q[DATA_BITS-1] == ($past(final_code[DATA_BITS-1]) ^ !$past(conv_coding_q)))
        else $error("output coding wrong");
    a_range_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        edge_mux && wr_en |=> range_o == $past(din_word_q[RANGE_POS]))
        else $error("range bit not applied");
    a_res_mask: assert property (@(posedge clk_i) disable iff (rst_i)
        sclk_fall && edge_q < EDGE_DONE && res_q == RES_8 |=> trial_code_o[3:0] == 4'h0)
        else $error("8-bit variant tried low bits");
endmodule

// ==== testbench/serial_host.sv ====
/*
 * Host serial master model for the converter sequencer bench.
 * Assumes the device samples control data on serial clock falls and
 * updates its result bit a few system clocks after each fall.
 */
`timescale 1ns/100ps

module serial_host (
    output logic cs_n_o,
    output logic sclk_o,
    output logic din_o,
    input wire logic dout_i,
    input wire logic dout_oe_i
);
    int falls;
    logic oe_seen;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
        falls = 0;
        oe_seen = 1'b0;
    end

    // ****************************************************************
    // One frame
    // ****************************************************************
    // The clock is slower than full rate; only the throughput suffers.
    task automatic frame(input logic [11:0] w, output logic [15:0] rd);
        cs_n_o <= 1'b0;
        din_o <= w[11];
        falls = 0;
        #62.5;
        rd[15] = dout_i;
        oe_seen = dout_oe_i;
        for (int i = 0; i < 16; i++) begin
            sclk_o <= 1'b0;
            falls = i + 1;
            #62.5;
            sclk_o <= 1'b1;
            if (i < 15) rd[14-i] = dout_i;
            // Past the control word the line toggles so that nothing stale looks valid.
            din_o <= (i < 11) ? w[10-i] : ~din_o;
            #62.5;
        end
        cs_n_o <= 1'b1;
        din_o <= ~din_o;
        #250;
    endtask
endmodule

// ==== testbench/testbench.sv ====
/*
 * Self-checking bench for the converter sequencer: serial frames through
 * the host model, registers through classic bus cycles.
 * Assumes the designer's offsets and a 250 MHz system clock.
 */
`timescale 1ns/100ps

module testbench;
    import adc_seq_pkg::*;

    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cs_n, sclk, din, dout, dout_oe, comparator = 1'b0, hold, range_q, cyc = 1'b0;
    logic stb = 1'b0, we = 1'b0, ack;
    logic [1:0] channel, pm;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [11:0] trial;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [11:0] vin [4] = '{12'h123, 12'h456, 12'h789, 12'habc};
    logic rng = 1'b1, cod = 1'b1;
    logic [1:0] res = 2'h2;
    int fail_count = 0, cmp_count = 0, cycles = 0;

    always #2 clk_i = ~clk_i;

    serial_host host (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout),
        .dout_oe_i(dout_oe));

    adc_channel_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .dout_o(dout), .dout_oe_o(dout_oe), .comparator_i(comparator),
        .channel_o(channel), .hold_o(hold), .range_o(range_q), .power_mode_o(pm),
        .trial_code_o(trial), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack));

    // ****************************************************************
    // Analog front end
    // ****************************************************************
    // Inputs are in steps of the narrow range; the wide range halves the code.
    always_ff @(posedge clk_i) begin
        comparator <= range_q ? ({1'b0, vin[channel]} >= {1'b0, trial})
                              : ({1'b0, vin[channel]} >= {trial, 1'b0});
    end

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            end_of_test();
        end
    end

    always @(channel) begin
        if (rst_i === 1'b0) check("mux switch edge", host.falls, 14);
    end

    // Halfway through the trials the sample must still be held.
    always @(posedge sclk) begin
        if (host.falls == 6) check("hold in conversion", {31'h0, hold}, 32'h1);
    end

    // ****************************************************************
    // Bus and frame helpers
    // ****************************************************************
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) check("bus ack", 0, 1);
    endtask

    function automatic logic [11:0] cw(input logic wr, s1, s0, input logic [1:0] ch,
        input logic r, c);
        return {wr, s1, 2'h0, ch, 2'h3, s0, 1'b0, r, c};
    endfunction

    function automatic logic [11:0] expect_data(input logic [1:0] ch);
        logic [11:0] v;
        v = rng ? vin[ch] : vin[ch] >> 1;
        if (res == RES_8) v &= 12'hff0;
        if (res == RES_10) v &= 12'hffc;
        v[11] = v[11] ^ ~cod;
        return v;
    endfunction

    task automatic xfer(input logic [11:0] w, input logic [1:0] ch, input bit pop);
        logic [15:0] rd;
        logic [31:0] r;
        logic [11:0] e;
        e = expect_data(ch);
        host.frame(w, rd);
        check("dout word", {16'h0, rd}, {18'h0, ch, e});
        check("oe in frame", {31'h0, host.oe_seen}, 32'h1);
        check("idle dout and oe", {30'h0, dout_oe, dout}, 32'h0);
        check("hold after done", {31'h0, hold}, 32'h0);
        check("power mode", {30'h0, pm}, 32'h3);
        if (w[11]) begin
            rng = w[1];
            cod = w[0];
        end
        check("range pin", {31'h0, range_q}, {31'h0, rng});
        if (pop) begin
            wb(OFS_RESULT, 1'b0, 32'h0, r);
            check("result", r, {15'h0, 1'b1, 2'h0, ch, e});
        end
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(OFS_CTRL, 1'b0, 32'h0, q);
        check("ctrl reset", q, 32'h33);
        wb(OFS_STATUS, 1'b0, 32'h0, q);
        check("status reset", q, 32'h2);
        wb(4'h2, 1'b1, 32'hffffffff, q);
        wb(4'h2, 1'b0, 32'h0, q);
        check("unmapped", q, 32'h0);
        wb(OFS_CFG, 1'b0, 32'h0, q);
        check("cfg reset", q, 32'h2);
        xfer(cw(1, 0, 0, 2, 1, 1), 0, 1);
        xfer(cw(0, 1, 1, 3, 0, 0), 2, 1);
        xfer(cw(1, 0, 1, 1, 1, 1), 2, 1);
        for (int i = 0; i < 4; i++) begin
            xfer(cw(1, 0, 0, 1, i[1], i[0]), 1, 1);
        end
        for (int i = 0; i < 4; i++) begin
            wb(OFS_CFG, 1'b1, i, q);
            res = (i > 2) ? 2'h2 : i[1:0];
            wb(OFS_CFG, 1'b0, 32'h0, q);
            check("cfg", q, {30'h0, res});
            xfer(12'h0, 1, 1);
        end
        xfer(cw(1, 1, 1, 2, 1, 1), 1, 1);
        for (int i = 0; i < 4; i++) begin
            xfer(12'h0, i[1:0] % 3, 1);
        end
        wb(OFS_CTRL, 1'b0, 32'h0, q);
        check("seq active", {31'h0, q[18]}, 32'h1);
        xfer(cw(1, 1, 0, 2, 1, 0), 1, 1);
        // Exit written on the very next transfer, as the host must.
        xfer(cw(1, 0, 0, 3, 1, 1), 2, 1);
        xfer(12'h0, 3, 1);
        for (int i = 0; i < 34; i++) xfer(12'h0, 3, 0);
        wb(OFS_STATUS, 1'b0, 32'h0, q);
        check("fifo full", {25'h0, q[13:8], q[0]}, {25'h0, 6'h20, 1'b1});
        // Thirty-two words in the FIFO plus the one that waited in the pending stage.
        for (int i = 0; i < 33; i++) begin
            wb(OFS_RESULT, 1'b0, 32'h0, q);
            check("drain", {27'h0, q[16:12]}, 32'h13);
        end
        wb(OFS_RESULT, 1'b0, 32'h0, q);
        check("empty pop", {31'h0, q[16]}, 32'h0);
        wb(OFS_STATUS, 1'b1, 32'h1, q);
        wb(OFS_STATUS, 1'b0, 32'h0, q);
        check("status clear", q, 32'h2);
        end_of_test();
    end
endmodule
